// ==== rtl/bpsp_pkg.sv ====
package bpsp_pkg;

  // ==========================================================================
  // Register map (byte addresses, one 32-bit word each)
  // ==========================================================================
  localparam logic [7:0] OFS_SERVICE_A   = 8'h00;
  localparam logic [7:0] OFS_LOGIN_ID    = 8'h04;
  localparam logic [7:0] OFS_CIPHER_ID   = 8'h08;
  localparam logic [7:0] OFS_ADDR_LO     = 8'h0c;
  localparam logic [7:0] OFS_ADDR_HI     = 8'h10;
  localparam logic [7:0] OFS_CTRL        = 8'h14;
  localparam logic [7:0] OFS_TERM_STATUS = 8'h18;
  localparam logic [7:0] OFS_NET_STATUS  = 8'h1c;
  localparam logic [7:0] OFS_PLAN_INFO   = 8'h20;
  localparam logic [7:0] OFS_GRANT_SEL   = 8'h24;
  localparam logic [7:0] OFS_GRANT_DATA  = 8'h28;
  localparam logic [7:0] OFS_DISCARDS    = 8'h2c;
  localparam logic [7:0] OFS_DESC_COUNT  = 8'h30;

  // ==========================================================================
  // Section layout
  // ==========================================================================
  localparam logic [7:0] PLAN_HDR_BYTES = 8'h08;
  localparam logic [7:0] INFO_HDR_BYTES = 8'h0c;
  localparam logic [7:0] HDR_ADDR_B5    = 8'h03;
  localparam logic [7:0] HDR_ADDR_B4    = 8'h04;
  localparam logic [7:0] HDR_ADDR_B3    = 8'h08;
  localparam logic [7:0] HDR_ADDR_B2    = 8'h09;
  localparam logic [7:0] HDR_ADDR_B1    = 8'h0a;
  localparam logic [7:0] HDR_ADDR_B0    = 8'h0b;
  localparam logic [7:0] BCAST_BYTE     = 8'hff;

  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;

  // Entry flag byte bit positions.
  localparam int FLG_MULTI = 7;
  localparam int FLG_QE    = 4;

  localparam logic [1:0] ASSIGN_ONCE    = 2'h0;
  localparam logic [1:0] ASSIGN_REPEAT  = 2'h1;
  localparam logic [1:0] ASSIGN_RELEASE = 2'h2;
  localparam logic [1:0] ASSIGN_RSVD    = 2'h3;

  // Status byte bits.
  localparam int ST_CIPHER    = 7;
  localparam int ST_LOGOFF    = 4;
  localparam int ST_TX_DIS    = 3;
  localparam int ST_RL_FAIL   = 2;
  localparam logic [7:0] NET_USED_MASK   = 8'h9f;
  localparam logic [7:0] NET_STATUS_RST  = 8'h00;
  localparam logic [7:0] TERM_STATUS_RST = 8'h00;

  typedef enum logic [20:0] {
    ST_IDLE    = 21'h000001,
    ST_HDR     = 21'h000002,
    ST_GRP     = 21'h000004,
    ST_SF_HI   = 21'h000008,
    ST_SF_LO   = 21'h000010,
    ST_FLC     = 21'h000020,
    ST_FNUM    = 21'h000040,
    ST_BLC_HI  = 21'h000080,
    ST_BLC_LO  = 21'h000100,
    ST_LID_HI  = 21'h000200,
    ST_LID_LO  = 21'h000400,
    ST_FLG     = 21'h000800,
    ST_SLOT_LO = 21'h001000,
    ST_CHAN    = 21'h002000,
    ST_ACNT    = 21'h004000,
    ST_STAT    = 21'h008000,
    ST_DLC     = 21'h010000,
    ST_DTAG    = 21'h020000,
    ST_DLEN    = 21'h040000,
    ST_DBODY   = 21'h080000,
    ST_TAIL    = 21'h100000
  } bpsp_state_t;

endpackage : bpsp_pkg

// ==== rtl/bpsp_parser.sv ====
// Notes on behaviour
// (R1) Plan applies only to own service group.
// (R2) Read 16-bit wrapping superframe counter.
// (R3) Frame loop count is entries minus one.
// (R4) Scan every block entry of each frame.
// (R5) Accept block only on group and login match.
// (R6) No multi-channel flag means channel zero.
// (R7) Decode assignment type; eleven is reserved.
// (R8) Keep queue-empty flag with each grant.
// (R9) Start slot is first slot in frame.
// (R10) Channel number present only with flag.
// (R11) Slot count is block length minus one.
// (R12) Section CRC must leave zero remainder.
// (R13) Bad CRC section changes nothing at all; the code still counts it in the discard counter.
// (R14) Parse all descriptors, then commit together.
// (R15) Broadcast values replace preset network defaults.
// (R16) Status byte owner chosen by header address.
// (R17) Descriptor loop count is count minus one.
// (R18) Reserved bits are ignored.
// (R19) Sender randomises reserved bits when encrypted.
// (R20) Terminal status flag bit meanings.
// (R21) Cipher flag switches login matching identity.
// (R22) Forced logoff stops transmission immediately.
// (R23) Transmit disable holds until unicast clears.
// (R24) Network status flag bit meanings.
// (R25) Return link failure stops until cleared.
//
// The register offsets and the APB register port were left to the implementer.
module bpsp_parser #(
  parameter int GRANT_DEPTH = 8
) (
  input  wire logic         ref_clk_in,
  input  wire logic         rst_b_in,
  input  wire logic         psel_in,
  input  wire logic         penable_in,
  input  wire logic         pwrite_in,
  input  wire logic [7:0]   paddr_in,
  input  wire logic [31:0]  pwdata_in,
  output logic      [31:0]  prdata_out,
  output logic              pready_out,
  output logic              pslverr_out,
  input  wire logic         sec_valid_in,
  input  wire logic         sec_first_in,
  input  wire logic         sec_last_in,
  input  wire logic         sec_kind_in,
  input  wire logic [7:0]   sec_data_in,
  output logic              tx_allow_out,
  output logic              cipher_active_out,
  output logic      [7:0]   term_status_out,
  output logic      [7:0]   net_status_out,
  output logic              section_ok_out,
  output logic              section_bad_out
);
  import bpsp_pkg::*;

  localparam int IDX_W = (GRANT_DEPTH > 1) ? $clog2(GRANT_DEPTH) : 1;
  localparam int CNT_W = $clog2(GRANT_DEPTH + 1);
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(GRANT_DEPTH);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    bpsp_state_t                     st;
    logic [7:0]                      cnt;
    logic [31:0]                     crc;
    logic                            kind;
    logic                            uni_ok;
    logic                            bc_ok;
    logic                            group_ok;
    logic [15:0]                     stg_sf;
    logic [4:0]                      frames_left;
    logic [10:0]                     blocks_left;
    logic [4:0]                      fnum;
    logic [15:0]                     lid;
    logic [7:0]                      flags;
    logic [10:0]                     start;
    logic [3:0]                      chan;
    logic [CNT_W-1:0]                stg_n;
    logic                            stg_ovf;
    logic [GRANT_DEPTH-1:0][31:0]    stg;
    logic [7:0]                      stat;
    logic [7:0]                      dleft;
    logic [8:0]                      dcnt;
    logic [7:0]                      reg_group;
    logic [15:0]                     reg_lid;
    logic [15:0]                     reg_cid;
    logic [31:0]                     reg_addr_lo;
    logic [15:0]                     reg_addr_hi;
    logic [IDX_W-1:0]                grant_sel;
    logic [7:0]                      term_stat;
    logic [7:0]                      net_stat;
    logic [15:0]                     plan_sf;
    logic [CNT_W-1:0]                plan_n;
    logic                            plan_ovf;
    logic [GRANT_DEPTH-1:0][31:0]    grants;
    logic                            logoff;
    logic                            hold;
    logic                            rlf;
    logic                            tx_allow;
    logic [15:0]                     discards;
    logic [8:0]                      desc_count;
    logic [31:0]                     prdata;
    logic                            pslverr;
    logic                            ok_pulse;
    logic                            bad_pulse;
  } bpsp_regs_t;

  localparam bpsp_regs_t Q_RST = '{
    st:        ST_IDLE,
    crc:       CRC_INIT,
    term_stat: TERM_STATUS_RST,
    net_stat:  NET_STATUS_RST,
    tx_allow:  1'b1,
    default:   '0
  };

  bpsp_regs_t q;
  bpsp_regs_t d;
  logic       c_good;
  logic       c_bad;
  logic       c_plan;
  logic       c_uni;
  logic       c_bc;
  logic       hit;
  logic       store;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // MSB-first CRC, no reflection; a correct section leaves zero behind.
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0]  b);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[31] ^ b[i]) begin
        r = {r[30:0], 1'b0} ^ CRC_POLY;
      end else begin
        r = {r[30:0], 1'b0};
      end
    end
    return r;
  endfunction : crc_byte

  function automatic logic is_mapped(input logic [7:0] a);
    return (a <= OFS_DESC_COUNT) && (a[1:0] == 2'h0);
  endfunction : is_mapped

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    logic [7:0]       b;
    logic [7:0]       exp_b;
    logic             chk;
    logic [15:0]      own_id;
    logic             end_desc;
    logic [31:0]      crc_n;
    logic [IDX_W-1:0] sidx;
    b        = sec_data_in;
    exp_b    = '0;
    chk      = 1'b0;
    end_desc = 1'b0;
    own_id   = '0;
    crc_n    = crc_byte(q.crc, b);
    sidx     = q.stg_n[IDX_W-1:0];
    d        = q;
    d.ok_pulse  = 1'b0;
    d.bad_pulse = 1'b0;
    c_good = 1'b0;
    c_bad  = 1'b0;
    c_plan = 1'b0;
    c_uni  = 1'b0;
    c_bc   = 1'b0;
    // (R21) cipher selects identity
    own_id = q.term_stat[ST_CIPHER] ? q.reg_cid : q.reg_lid;
    // (R5) group and login match
    hit   = q.group_ok && (q.lid == own_id);
    // (R7) reserved type dropped
    store = sec_valid_in && !sec_first_in && (q.st == ST_ACNT) && hit &&
            (q.flags[6:5] != ASSIGN_RSVD) && (q.stg_n < DEPTH_C);

    // Register bus: read data is captured in the setup cycle.
    if (psel_in && !penable_in) begin
      d.pslverr = !is_mapped(paddr_in);
      case (paddr_in)
        OFS_SERVICE_A:   d.prdata = {24'h0, q.reg_group};
        OFS_LOGIN_ID:    d.prdata = {16'h0, q.reg_lid};
        OFS_CIPHER_ID:   d.prdata = {16'h0, q.reg_cid};
        OFS_ADDR_LO:     d.prdata = q.reg_addr_lo;
        OFS_ADDR_HI:     d.prdata = {16'h0, q.reg_addr_hi};
        OFS_CTRL:        d.prdata = {28'h0, q.tx_allow, q.rlf, q.hold,
                                     q.logoff};
        OFS_TERM_STATUS: d.prdata = {24'h0, q.term_stat};
        OFS_NET_STATUS:  d.prdata = {24'h0, q.net_stat};
        OFS_PLAN_INFO:   d.prdata = {7'h0, q.plan_ovf, 8'(q.plan_n),
                                     q.plan_sf};
        OFS_GRANT_SEL:   d.prdata = 32'(q.grant_sel);
        OFS_GRANT_DATA:  d.prdata = q.grants[q.grant_sel];
        OFS_DISCARDS:    d.prdata = {16'h0, q.discards};
        OFS_DESC_COUNT:  d.prdata = {23'h0, q.desc_count};
        default:         d.prdata = 32'h0;
      endcase
    end
    if (psel_in && penable_in && pwrite_in) begin
      case (paddr_in)
        OFS_SERVICE_A: d.reg_group   = pwdata_in[7:0];
        OFS_LOGIN_ID:  d.reg_lid     = pwdata_in[15:0];
        OFS_CIPHER_ID: d.reg_cid     = pwdata_in[15:0];
        OFS_ADDR_LO:   d.reg_addr_lo = pwdata_in;
        OFS_ADDR_HI:   d.reg_addr_hi = pwdata_in[15:0];
        OFS_CTRL: begin
          // Writing 1 to bit 0 signals a fresh logon.
          if (pwdata_in[0]) begin
            d.logoff = 1'b0;
          end
        end
        OFS_GRANT_SEL: d.grant_sel   = pwdata_in[IDX_W-1:0];
        default: begin
        end
      endcase
    end

    // Section byte stream.
    if (sec_valid_in) begin
      if (sec_first_in) begin
        d.crc      = crc_byte(CRC_INIT, b);
        d.kind     = sec_kind_in;
        d.cnt      = 8'h01;
        d.uni_ok   = 1'b1;
        d.bc_ok    = 1'b1;
        d.group_ok = 1'b0;
        d.stg_n    = '0;
        d.stg_ovf  = 1'b0;
        d.dcnt     = '0;
        d.st       = ST_HDR;
      end else begin
        d.crc = crc_n;
        case (q.st)
          ST_HDR: begin
            // (R16) header address compare
            case (q.cnt)
              HDR_ADDR_B5: begin chk = 1'b1; exp_b = q.reg_addr_hi[15:8]; end
              HDR_ADDR_B4: begin chk = 1'b1; exp_b = q.reg_addr_hi[7:0];  end
              HDR_ADDR_B3: begin chk = 1'b1; exp_b = q.reg_addr_lo[31:24]; end
              HDR_ADDR_B2: begin chk = 1'b1; exp_b = q.reg_addr_lo[23:16]; end
              HDR_ADDR_B1: begin chk = 1'b1; exp_b = q.reg_addr_lo[15:8]; end
              HDR_ADDR_B0: begin chk = 1'b1; exp_b = q.reg_addr_lo[7:0];  end
              default: begin
              end
            endcase
            if (chk && (b != exp_b)) begin
              d.uni_ok = 1'b0;
            end
            if (chk && (b != BCAST_BYTE)) begin
              d.bc_ok = 1'b0;
            end
            d.cnt = q.cnt + 8'h01;
            if (q.kind && (q.cnt == INFO_HDR_BYTES - 8'h01)) begin
              d.st = ST_STAT;
            end else if (!q.kind && (q.cnt == PLAN_HDR_BYTES - 8'h01)) begin
              d.st = ST_GRP;
            end
          end
          ST_GRP: begin
            // (R1) service group filter
            d.group_ok = (b == q.reg_group);
            d.st       = ST_SF_HI;
          end
          ST_SF_HI: begin
            // (R2) superframe counter
            d.stg_sf[15:8] = b;
            d.st           = ST_SF_LO;
          end
          ST_SF_LO: begin
            d.stg_sf[7:0] = b;
            d.st          = ST_FLC;
          end
          ST_FLC: begin
            // (R3) frame loop count
            d.frames_left = b[4:0];
            d.st          = ST_FNUM;
          end
          ST_FNUM: begin
            d.fnum = b[4:0];
            d.st   = ST_BLC_HI;
          end
          ST_BLC_HI: begin
            d.blocks_left[10:8] = b[2:0];
            d.st                = ST_BLC_LO;
          end
          ST_BLC_LO: begin
            d.blocks_left[7:0] = b;
            d.st               = ST_LID_HI;
          end
          ST_LID_HI: begin
            d.lid[15:8] = b;
            d.st        = ST_LID_LO;
          end
          ST_LID_LO: begin
            d.lid[7:0] = b;
            d.st       = ST_FLG;
          end
          ST_FLG: begin
            d.flags = b;
            d.st    = ST_SLOT_LO;
          end
          ST_SLOT_LO: begin
            // (R9) start slot, reserved bit dropped
            d.start = {q.flags[2:0], b};
            // (R6) default channel zero
            d.chan  = 4'h0;
            d.st    = q.flags[FLG_MULTI] ? ST_CHAN : ST_ACNT;
          end
          ST_CHAN: begin
            // (R10) channel number
            d.chan = b[3:0];
            d.st   = ST_ACNT;
          end
          ST_ACNT: begin
            // (R11) grant record with slot count
            if (store) begin
              // (R8) queue-empty kept per grant
              d.stg[sidx] = {1'b0, q.flags[6:5], q.flags[FLG_QE], q.chan,
                             q.fnum, q.start, b};
              d.stg_n     = q.stg_n + CNT_W'(1);
            end else if (hit && (q.flags[6:5] != ASSIGN_RSVD)) begin
              d.stg_ovf = 1'b1;
            end
            // (R4) scan whole block loop
            if (q.blocks_left != 11'h0) begin
              d.blocks_left = q.blocks_left - 11'h1;
              d.st          = ST_LID_HI;
            end else if (q.frames_left != 5'h0) begin
              d.frames_left = q.frames_left - 5'h1;
              d.st          = ST_FNUM;
            end else begin
              d.st = ST_TAIL;
            end
          end
          ST_STAT: begin
            d.stat = b;
            d.st   = ST_DLC;
          end
          ST_DLC: begin
            // (R17) descriptor loop count
            d.dleft = b;
            d.st    = ST_DTAG;
          end
          ST_DTAG: begin
            d.dcnt = q.dcnt + 9'h001;
            d.st   = ST_DLEN;
          end
          ST_DLEN: begin
            d.cnt = b;
            if (b == 8'h00) begin
              end_desc = 1'b1;
            end else begin
              d.st = ST_DBODY;
            end
          end
          ST_DBODY: begin
            d.cnt = q.cnt - 8'h01;
            if (q.cnt == 8'h01) begin
              end_desc = 1'b1;
            end
          end
          ST_TAIL, ST_IDLE: begin
          end
          default: d.st = ST_IDLE;
        endcase
        if (end_desc) begin
          d.dleft = q.dleft - 8'h01;
          d.st    = (q.dleft == 8'h00) ? ST_TAIL : ST_DTAG;
        end
      end

      if (sec_last_in) begin
        // (R12) zero remainder check
        c_good = !sec_first_in && (crc_n == 32'h0) && (d.st == ST_TAIL);
        // (R13) discard bad sections
        c_bad  = !c_good;
        c_plan = c_good && !q.kind && q.group_ok;
        c_uni  = c_good && q.kind && q.uni_ok;
        c_bc   = c_good && q.kind && q.bc_ok && !q.uni_ok;
        d.st   = ST_IDLE;
        d.ok_pulse  = c_good;
        d.bad_pulse = c_bad;
        if (c_bad) begin
          d.discards = q.discards + 16'h0001;
        end
        if (c_plan) begin
          d.plan_sf  = q.stg_sf;
          d.plan_n   = q.stg_n;
          d.plan_ovf = q.stg_ovf;
          d.grants   = q.stg;
        end
        // (R14) commit after all descriptors
        if (c_uni) begin
          // (R20) terminal status flags
          d.term_stat  = q.stat;
          d.desc_count = q.dcnt;
          // (R22) forced logoff wins
          if (q.stat[ST_LOGOFF]) begin
            d.logoff = 1'b1;
          end
          // (R23) hold follows unicast flag
          d.hold = q.stat[ST_TX_DIS];
        end
        if (c_bc) begin
          // (R15) (R18) (R24) broadcast overrides defaults
          d.net_stat   = q.stat & NET_USED_MASK;
          d.desc_count = q.dcnt;
          // (R25) return link failure
          d.rlf = q.stat[ST_RL_FAIL];
        end
      end
    end
    d.tx_allow = !(d.logoff || d.hold || d.rlf);
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= Q_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Zero wait states: every access completes in its first access cycle.
  assign pready_out        = 1'b1;
  assign prdata_out        = q.prdata;
  assign pslverr_out       = q.pslverr && psel_in && penable_in;
  assign tx_allow_out      = q.tx_allow;
  assign cipher_active_out = q.term_stat[ST_CIPHER];
  assign term_status_out   = q.term_stat;
  assign net_status_out    = q.net_stat;
  assign section_ok_out    = q.ok_pulse;
  assign section_bad_out   = q.bad_pulse;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_last_byte;
    sec_valid_in && sec_last_in;
  endsequence

  sequence s_uni_commit_clear;
    c_uni && !q.stat[ST_TX_DIS];
  endsequence

  AST_CRC_DISCARD: assert property ( // (R13)
    s_last_byte ##0 c_bad |=> $stable(q.plan_sf) && $stable(q.term_stat)
      && $stable(q.net_stat) && $stable(q.plan_n))
    else $error("bad section changed committed state");

  AST_CRC_COUNT: assert property ( // (R12)
    s_last_byte ##0 (crc_byte(q.crc, sec_data_in) != 32'h0) |=>
      section_bad_out && (q.discards == $past(q.discards) + 16'h0001))
    else $error("nonzero remainder not counted as discard");

  AST_GROUP_ONLY: assert property ( // (R1)
    sec_valid_in && !sec_first_in && (q.st == ST_ACNT) && !q.group_ok
      |=> $stable(q.stg_n))
    else $error("grant stored for foreign group");

  AST_STORE_COUNT: assert property ( // (R5)
    store |=> q.stg_n == $past(q.stg_n) + CNT_W'(1))
    else $error("matched block not staged");

  AST_CHAN_ZERO: assert property ( // (R6)
    sec_valid_in && !sec_first_in && (q.st == ST_SLOT_LO)
      && !q.flags[FLG_MULTI] && !sec_last_in
      |=> (q.st == ST_ACNT) && (q.chan == 4'h0))
    else $error("single channel entry not on channel zero");

  AST_LOOP_END: assert property ( // (R4)
    sec_valid_in && !sec_first_in && !sec_last_in && (q.st == ST_ACNT)
      && (q.blocks_left == 11'h0) && (q.frames_left == 5'h0)
      |=> q.st == ST_TAIL)
    else $error("loop did not end after last entry");

  AST_LOGOFF_STOP: assert property ( // (R22)
    c_uni && q.stat[ST_LOGOFF] |=> !tx_allow_out && q.logoff)
    else $error("forced logoff did not stop transmission");

  AST_HOLD_STAYS: assert property ( // (R23)
    q.hold && !c_uni |=> q.hold && !tx_allow_out)
    else $error("hold left without unicast message");

  AST_HOLD_RELEASE: assert property ( // (R23)
    s_uni_commit_clear |=> !q.hold)
    else $error("hold not released by clearing message");

  AST_RLF_STOP: assert property ( // (R25)
    c_bc && q.stat[ST_RL_FAIL] |=> !tx_allow_out ##1
      (q.rlf || $past(c_bc)))
    else $error("return link failure did not stop transmission");

  AST_DESC_COMMIT: assert property ( // (R14)
    c_uni |=> q.desc_count == $past(q.dcnt))
    else $error("descriptor count not committed");

  AST_NET_RESERVED: assert property ( // (R18)
    q.net_stat[6:5] == 2'h0)
    else $error("reserved network status bits stored");

endmodule : bpsp_parser

// ==== test/bpsp_ncc_model.sv ====
module bpsp_ncc_model
  import bpsp_pkg::*;
(
  input  wire logic       ref_clk_in,
  output logic            sec_valid_out,
  output logic            sec_first_out,
  output logic            sec_last_out,
  output logic            sec_kind_out,
  output logic [7:0]      sec_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sec_valid_out = 1'b0;
    sec_first_out = 1'b0;
    sec_last_out  = 1'b0;
    sec_kind_out  = 1'b0;
    sec_data_out  = 8'h00;
  end
  task automatic send(input logic k, input logic [7:0] q[$], input logic bad);
    logic [31:0] c;
    c = CRC_INIT;
    foreach (q[i]) for (int b = 7; b >= 0; b--) begin
      c = {c[30:0], 1'b0} ^ ((c[31] ^ q[i][b]) ? CRC_POLY : 32'h0);
    end
    c[0] = c[0] ^ bad;
    q = {q, c[31:24], c[23:16], c[15:8], c[7:0]};
    foreach (q[i]) begin
      @(posedge ref_clk_in);
      sec_valid_out <= 1'b1;
      sec_first_out <= (i == 0);
      sec_last_out  <= (i == q.size() - 1);
      sec_kind_out  <= k;
      sec_data_out  <= q[i];
    end
    @(posedge ref_clk_in);
    sec_valid_out <= 1'b0;
    sec_first_out <= 1'b0;
    sec_last_out  <= 1'b0;
    // Idle data is inverted so a stale byte is never mistaken for data.
    sec_data_out  <= ~q[q.size() - 1];
  endtask : send
endmodule : bpsp_ncc_model

// ==== test/burst_plan_status_parser_tb.sv ====
module burst_plan_status_parser_tb;
  import bpsp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, psel, penable, pwrite, sv, sf, sl, sk, pready, perr;
  logic tx, ciph, ok, bad;
  logic [7:0]  paddr, sd, tst, nst;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  q[$];
  logic e;
  int mismatches, num_checks;
  always #4 clk = ~clk;
  bpsp_parser #(.GRANT_DEPTH(4)) u_dut (.ref_clk_in(clk), .rst_b_in(rst_b),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(perr), .sec_valid_in(sv),
    .sec_first_in(sf), .sec_last_in(sl), .sec_kind_in(sk), .sec_data_in(sd),
    .tx_allow_out(tx), .cipher_active_out(ciph), .term_status_out(tst),
    .net_status_out(nst), .section_ok_out(ok), .section_bad_out(bad));
  bpsp_ncc_model u_ncc (.ref_clk_in(clk), .sec_valid_out(sv),
    .sec_first_out(sf), .sec_last_out(sl), .sec_kind_out(sk),
    .sec_data_out(sd));
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin mismatches++; tally_and_finish(); end
    r = prdata;
    e = perr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic sec(input logic k, input logic [7:0] s[$], input logic b);
    int n;
    u_ncc.send(k, s, b);
    n = 0;
    do begin @(posedge clk); n++; end while (ok !== 1'b1 && bad !== 1'b1 && n < 8);
    if (ok !== 1'b1 && bad !== 1'b1) begin mismatches++; tally_and_finish(); end
    chk("section_bad", {31'h0, b}, {31'h0, bad});
  endtask : sec
  task automatic info(input logic bc, input logic [7:0] st, input logic b);
    q = {8'h3e, 8'h00, 8'h00, 8'h12, 8'h34, 8'h00, 8'h00, 8'h00, 8'h56, 8'h78,
         8'h9a, 8'hbc, st, 8'h00, 8'h41, 8'h00};
    if (bc) for (int i = 0; i < 12; i++) q[i] = 8'hff;
    if (!bc) q.push_back(~st); // varied pad byte
    sec(1'b1, q, b);
  endtask : info
  task automatic t_plan();
    apb(1'b1, OFS_SERVICE_A, 32'h05);
    apb(1'b1, OFS_LOGIN_ID, 32'h42);
    q = {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h05, 8'hab,
         8'hcd, 8'he0, 8'h03, 8'h00, 8'h02, 8'h0b, 8'hbb, 8'h00, 8'h00, 8'h00,
         8'h00, 8'h42, 8'h31, 8'h23, 8'h05, 8'h00, 8'h42, 8'hc0, 8'h07, 8'hf9,
         8'h00};
    sec(1'b0, q, 1'b0);
    apb(1'b0, OFS_PLAN_INFO, 32'h0);
    chk("plan_info", 32'h0002abcd, r);
    apb(1'b1, OFS_GRANT_SEL, 32'h0);
    apb(1'b0, OFS_GRANT_DATA, 32'h0);
    chk("grant0", 32'h30192305, r);
    apb(1'b1, OFS_GRANT_SEL, 32'h1);
    apb(1'b0, OFS_GRANT_DATA, 32'h0);
    chk("grant1", 32'h49180700, r);
    q[10] = 8'h11;
    q[22] = 8'h71;
    sec(1'b0, q, 1'b0);
    apb(1'b0, OFS_PLAN_INFO, 32'h0);
    chk("reserved_type", 32'h0001ab11, r);
    q[8] = 8'h06;
    q[10] = 8'h00;
    sec(1'b0, q, 1'b0);
    apb(1'b0, OFS_PLAN_INFO, 32'h0);
    chk("foreign_group", 32'h0001ab11, r);
    $display("test plan done");
  endtask : t_plan
  task automatic t_net();
    info(1'b1, 8'hff, 1'b0);
    chk("net_status", 32'h9f, {24'h0, nst});
    chk("tx_allow", 32'h0, {31'h0, tx});
    info(1'b1, 8'h00, 1'b0);
    chk("tx_allow", 32'h1, {31'h0, tx});
    $display("test network done");
  endtask : t_net
  task automatic t_term();
    info(1'b0, 8'h08, 1'b0);
    chk("term_status", 32'h08, {24'h0, tst});
    chk("tx_allow", 32'h0, {31'h0, tx});
    apb(1'b0, OFS_DESC_COUNT, 32'h0);
    chk("desc_count", 32'h1, r);
    info(1'b0, 8'h00, 1'b0);
    chk("tx_allow", 32'h1, {31'h0, tx});
    info(1'b0, 8'h10, 1'b1);
    chk("term_status", 32'h0, {24'h0, tst});
    info(1'b0, 8'h10, 1'b0);
    chk("tx_allow", 32'h0, {31'h0, tx});
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", 32'h1, r);
    apb(1'b0, 8'h34, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, e});
    info(1'b0, 8'h80, 1'b0);
    chk("cipher", 32'h1, {31'h0, ciph});
    $display("test terminal done");
  endtask : t_term
  initial begin
    {clk, rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b1, OFS_ADDR_HI, 32'h1234);
    apb(1'b1, OFS_ADDR_LO, 32'h56789abc);
    t_plan();
    t_net();
    t_term();
    tally_and_finish();
  end
endmodule : burst_plan_status_parser_tb
